// ---- ascal_pkg.sv ----
/*
  Constants and types for the converter serial-frame and offset-calibration block.
  Assumes one system clock at 10 MHz; the serial clock and chip select arrive as asynchronous pins.
*/
package ascal_pkg;

  localparam int unsigned RES_BITS      = 8;
  localparam int unsigned CNT_BITS      = 6;
  localparam int unsigned FIFO_DEPTH    = 8;

  localparam logic [7:0]  LOWEST_CODE   = 8'h00;
  localparam logic [7:0]  MIDDLE_CODE   = 8'h80;
  localparam logic [7:0]  HIGHEST_CODE  = 8'hFF;
  localparam logic [7:0]  OFFSET_RESET  = 8'h00;

  // Falling-edge counts within a frame
  localparam logic [5:0]  LEAD_ZEROS    = 6'h01;
  localparam logic [5:0]  ORD_LOW_AFTER = 6'h0E;
  localparam logic [5:0]  LONG_LOW_AFTER = 6'h0A;
  localparam logic [5:0]  PWR_CAL_EDGES = 6'h10;
  localparam logic [5:0]  CAL_START_EDGE = 6'h11;
  localparam logic [5:0]  CAL_END_EDGE  = 6'h20;
  localparam logic [5:0]  CAL_MIN_PERIODS = 6'h0F;

  localparam int unsigned ACQ_NS        = 120;
  localparam int unsigned CLK_NS        = 100;
  localparam int unsigned ACQ_CYC       = (ACQ_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ASCAL_IDLE,
    ASCAL_CONV,
    ASCAL_PWRCAL
  } ascal_state_e;

  typedef struct packed {
    logic [7:0] code;
    logic       cal;
  } ascal_sample_s;

endpackage

// ---- ascal_fifo.sv ----
/*
  Small parameterised FIFO with valid/ready on both sides.
  Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
module ascal_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             wr;
  logic             rd;

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign wr = i_in_valid & o_in_ready;
  assign rd = o_out_valid & i_out_ready;

  always_ff @(posedge i_mclk) begin
    if (wr) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  // Registered read data: next word is preloaded when the head is popped
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out_data <= '0;
    end else if (rd && cnt_r > (AW+1)'(1)) begin
      o_out_data <= mem_r[rp_r + AW'(1)];
    end else if (wr && (cnt_r == '0 || (rd && cnt_r == (AW+1)'(1)))) begin
      o_out_data <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) begin
        wp_r <= wp_r + AW'(1);
      end
      if (rd) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule // ascal_fifo

// ---- ascal_sync.sv ----
/*
  Two-flop synchroniser with falling and rising edge pulses taken from the settled stage.
  Assumes asynchronous pin input and one system clock.
*/
`timescale 1ns/10ps
module ascal_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // Pin and results
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_fall,
  output logic      o_rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // First stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign o_level = s2_r;
  assign o_fall  = s3_r & ~s2_r;
  assign o_rise  = ~s3_r & s2_r;
endmodule // ascal_sync

// ---- ascal_top.sv ----
/*
  Digital side of an 8-bit sampling converter: frames, serial output, offset calibration.
  Assumes the host drives chip select and serial clock slower than a quarter of i_mclk, and
  the analog core hands raw codes through a FIFO with valid/ready.
*/
`timescale 1ns/10ps
module ascal_top
  import ascal_pkg::*;
(
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_nrst,
  // Serial link pins
  input  wire logic                i_cs_n,
  input  wire logic                i_sclk,
  output logic                     o_sdo,
  output logic                     o_sdo_oe,
  // Analog core: raw conversion codes and offset measurements
  input  wire logic                i_raw_valid,
  input  wire logic [RES_BITS-1:0] i_raw_code,
  input  wire logic                i_raw_is_cal,
  output logic                     o_raw_ready,
  // Analog core control
  output logic                     o_sample,
  output logic                     o_inputs_isolated,
  output logic                     o_cal_busy,
  output logic [RES_BITS-1:0]      o_offset
);
  logic          cs_lvl;
  logic          cs_fall;
  logic          cs_rise;
  logic          sck_fall;
  logic          fifo_valid;
  logic          fifo_ready;
  ascal_sample_s fifo_word;
  ascal_sample_s raw_word;

  ascal_state_e              state_r;
  logic [CNT_BITS-1:0]       edges_r;
  logic                      edges_sat_r;
  logic                      first_frame_r;
  logic [RES_BITS-1:0]       offset_correction_store_r;
  logic [RES_BITS-1:0]       shift_r;
  logic [RES_BITS-1:0]       meas_r;
  logic                      meas_ok_r;
  logic                      sdo_r;
  logic                      oe_r;
  logic                      cal_active_r;
  logic                      sample_r;

  function automatic logic [RES_BITS-1:0] correct(input logic [RES_BITS-1:0] raw,
                                                  input logic [RES_BITS-1:0] ofs);
    logic [RES_BITS:0] d;
    d = {1'b0, raw} - {1'b0, ofs};
    // Clamp to the lowest code instead of wrapping below zero
    correct = d[RES_BITS] ? LOWEST_CODE : d[RES_BITS-1:0];
  endfunction

  ascal_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_pin   (i_cs_n),
    .o_level (cs_lvl),
    .o_fall  (cs_fall),
    .o_rise  (cs_rise)
  );

  // Serial clock idles high; a low reset value would fake an edge right after reset
  ascal_sync #(.RST_VAL(1'b1)) u_sck_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_pin   (i_sclk),
    .o_level (),
    .o_fall  (sck_fall),
    .o_rise  ()
  );

  assign raw_word.code = i_raw_code;
  assign raw_word.cal  = i_raw_is_cal;

  ascal_fifo #(.WIDTH($bits(ascal_sample_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_raw_valid),
    .i_in_data   (raw_word),
    .o_in_ready  (o_raw_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_word),
    .i_out_ready (fifo_ready)
  );

  // Drain only while a frame is open so results are matched to their frame
  assign fifo_ready = (state_r != ASCAL_IDLE) & ~cs_lvl;

  // Frame state
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r       <= ASCAL_IDLE;
      first_frame_r <= 1'b1;
    end else if (cs_rise) begin
      state_r <= ASCAL_IDLE;
    end else if (cs_fall) begin
      state_r       <= first_frame_r ? ASCAL_PWRCAL : ASCAL_CONV;
      first_frame_r <= 1'b0;
    end
  end

  // Falling-edge counter, saturating so very long frames stay long
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      edges_r     <= '0;
      edges_sat_r <= 1'b0;
    end else if (cs_fall) begin
      edges_r     <= '0;
      edges_sat_r <= 1'b0;
    end else if (sck_fall && !cs_lvl && !edges_sat_r) begin
      edges_r <= edges_r + CNT_BITS'(1);
      if (edges_r == {CNT_BITS{1'b1}} - CNT_BITS'(1)) begin
        edges_sat_r <= 1'b1;
      end
    end
  end

  // Calibration window: isolates inputs while measuring offset
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cal_active_r <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      cal_active_r <= cs_fall && first_frame_r;
    end else if (sck_fall && state_r == ASCAL_CONV && edges_r == CAL_START_EDGE - CNT_BITS'(1)) begin
      cal_active_r <= 1'b1;
    end else if (sck_fall && state_r == ASCAL_CONV && edges_r == CAL_END_EDGE - CNT_BITS'(1)) begin
      cal_active_r <= 1'b0;
    end else if (sck_fall && state_r == ASCAL_PWRCAL && edges_r == PWR_CAL_EDGES - CNT_BITS'(1)) begin
      cal_active_r <= 1'b0;
    end
  end

  assign o_inputs_isolated = cal_active_r;
  assign o_cal_busy        = cal_active_r;

  // Sample strobe to the analog core at the start of each frame
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_r <= 1'b0;
    end else begin
      sample_r <= cs_fall;
    end
  end
  assign o_sample = sample_r;

  // Capture offset measurement from the analog core during the frame
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      meas_r    <= OFFSET_RESET;
      meas_ok_r <= 1'b0;
    end else if (cs_fall) begin
      meas_ok_r <= 1'b0;
    end else if (fifo_valid && fifo_ready && fifo_word.cal) begin
      meas_r    <= fifo_word.code;
      meas_ok_r <= 1'b1;
    end
  end

  // Correction store: only updated when enough edges arrived in the frame
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      offset_correction_store_r <= OFFSET_RESET;
    end else if (cs_rise && meas_ok_r) begin
      if (state_r == ASCAL_PWRCAL && (edges_sat_r || edges_r >= PWR_CAL_EDGES)) begin
        offset_correction_store_r <= meas_r;
      end else if (state_r == ASCAL_CONV && (edges_sat_r || edges_r >= CAL_END_EDGE)) begin
        offset_correction_store_r <= meas_r;
      end
    end
  end
  // Exposed to the analog side only; never on the serial output
  assign o_offset = offset_correction_store_r;

  // Output shifter
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_r <= '0;
    end else if (fifo_valid && fifo_ready && !fifo_word.cal && state_r == ASCAL_CONV) begin
      shift_r <= correct(fifo_word.code, offset_correction_store_r);
    end else if (sck_fall && !cs_lvl && edges_r >= LEAD_ZEROS) begin
      shift_r <= {shift_r[RES_BITS-2:0], 1'b0};
    end
  end

  // Serial data and its enable
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end else if (cs_rise || state_r == ASCAL_IDLE && !cs_fall) begin
      sdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end else if (cs_fall) begin
      sdo_r <= 1'b0;
      oe_r  <= 1'b1;
    end else if (state_r == ASCAL_PWRCAL) begin
      sdo_r <= 1'b0;
    end else if (sck_fall) begin
      if (edges_r < LEAD_ZEROS) begin
        sdo_r <= 1'b0;
      end else if (edges_r >= LONG_LOW_AFTER - CNT_BITS'(1) && (edges_r >= ORD_LOW_AFTER - CNT_BITS'(1)
                   || edges_r >= LONG_LOW_AFTER - CNT_BITS'(1))) begin
        // Frame length is unknown at edge 10, so low from there covers both frame kinds
        sdo_r <= 1'b0;
      end else begin
        sdo_r <= shift_r[RES_BITS-1];
      end
    end
  end

  assign o_sdo    = sdo_r;
  assign o_sdo_oe = oe_r;
endmodule // ascal_top

// ---- ascal_checker.sv ----
/*
  Concurrent checks on the serial frame, output release and calibration windows of ascal_top.
  Assumes it is bound to ascal_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module ascal_checker
  import ascal_pkg::*;
(
  // Clock and reset
  input wire logic                i_mclk,
  input wire logic                i_nrst,
  // Serial link pins
  input wire logic                i_cs_n,
  input wire logic                i_sclk,
  input wire logic                o_sdo,
  input wire logic                o_sdo_oe,
  // Analog core side
  input wire logic                i_raw_valid,
  input wire logic [RES_BITS-1:0] i_raw_code,
  input wire logic                i_raw_is_cal,
  input wire logic                o_raw_ready,
  input wire logic                o_sample,
  input wire logic                o_inputs_isolated,
  input wire logic                o_cal_busy,
  input wire logic [RES_BITS-1:0] o_offset
);
  logic [2:0] cs_q;
  logic [2:0] ck_q;
  logic [5:0] fall_cnt;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Own synchronisers; edge counts may lead or trail the design by a cycle, so bounds allow one
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_q <= 3'h7;
      ck_q <= 3'h7;
    end else begin
      cs_q <= {cs_q[1:0], i_cs_n};
      ck_q <= {ck_q[1:0], i_sclk};
    end
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fall_cnt <= 6'h00;
    end else if (cs_q[2] && !cs_q[1]) begin
      fall_cnt <= 6'h00;
    end else if (!cs_q[1] && ck_q[2] && !ck_q[1] && fall_cnt != 6'h3F) begin
      fall_cnt <= fall_cnt + 6'h01;
    end
  end
  property p_oe_on; $fell(i_cs_n) |-> ##[2:5] o_sdo_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data enable late after select fall");
  property p_oe_off; $rose(i_cs_n) |-> ##[2:5] !o_sdo_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data output not released");
  property p_bit0; $rose(o_sdo_oe) |-> !o_sdo; endproperty
  a_bit0: assert property (p_bit0) else $error("first bit not zero");
  property p_sample; o_sample |-> o_sdo_oe ##1 !o_sample; endproperty
  a_sample: assert property (p_sample) else $error("sample pulse malformed");
  property p_late_low; $past(fall_cnt, 2) >= 6'h0A |-> !o_sdo; endproperty
  a_late_low: assert property (p_late_low) else $error("data high after tenth edge");
  property p_iso_busy;
    (o_inputs_isolated == o_cal_busy) && !(cs_q[2] && cs_q[1] && o_inputs_isolated);
  endproperty
  a_iso_busy: assert property (p_iso_busy) else $error("isolation and busy differ");
  property p_iso_quiet; o_inputs_isolated |-> !o_sdo; endproperty
  a_iso_quiet: assert property (p_iso_quiet) else $error("data high during calibration");
  property p_iso_start;
    $rose(o_inputs_isolated) |-> fall_cnt <= 6'h01 || (fall_cnt >= 6'h10 && fall_cnt <= 6'h12);
  endproperty
  a_iso_start: assert property (p_iso_start) else $error("calibration started at wrong edge");
  property p_iso_end;
    $fell(o_inputs_isolated) |-> cs_q[1] || cs_q[2] || (fall_cnt >= 6'h0F && fall_cnt <= 6'h11)
      || (fall_cnt >= 6'h1F && fall_cnt <= 6'h21);
  endproperty
  a_iso_end: assert property (p_iso_end) else $error("calibration ended at wrong edge");
  property p_ofs_hold; $changed(o_offset) |-> $past(i_cs_n, 2); endproperty
  a_ofs_hold: assert property (p_ofs_hold) else $error("store changed inside a frame");
  property p_ofs_reset; $rose(i_nrst) |-> o_offset == OFFSET_RESET; endproperty
  a_ofs_reset: assert property (p_ofs_reset) else $error("store not clear after reset");
endmodule // ascal_checker

bind ascal_top ascal_checker i_ascal_checker (.i_mclk, .i_nrst, .i_cs_n, .i_sclk, .o_sdo, .o_sdo_oe,
  .i_raw_valid, .i_raw_code, .i_raw_is_cal, .o_raw_ready, .o_sample, .o_inputs_isolated, .o_cal_busy, .o_offset);

// ---- ascal_host.sv ----
/*
  Serial host model: frames under select, 800 ns serial clock, captures one data bit per edge.
  Assumes a 10 MHz system clock to pace itself; the clock idles high between frames.
*/
`timescale 1ns/10ps
module ascal_host (
  // Pacing clock and data line
  input  wire logic i_mclk,
  input  wire logic i_sdo_line,
  // Pins and capture
  output logic        o_cs_n,
  output logic        o_sclk,
  output logic        o_done,
  output logic [32:0] o_bits
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_done = 1'b0;
    o_bits = 33'h0;
  end
  // Bit k is taken just before fall k+1, so the slow synchroniser path has long settled
  task automatic frame(input int n_edges);
    int k;
    o_bits <= 33'h0;
    o_cs_n <= 1'b0;
    repeat (8) @(posedge i_mclk);
    for (k = 0; k < n_edges; k++) begin
      o_bits[k] <= i_sdo_line;
      o_sclk <= 1'b0;                      // Far below full rate, the pins are oversampled
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_mclk);
    end
    o_bits[n_edges] <= i_sdo_line;
    o_cs_n <= 1'b1;
    repeat (10) @(posedge i_mclk);
    o_done <= 1'b1;
    @(posedge i_mclk);
    o_done <= 1'b0;
  endtask
endmodule // ascal_host

// ---- tb.sv ----
/*
  Self-checking bench for ascal_top: host frames, analog core words, calibration and clamping.
  Assumes the host model in ascal_host and the bound checker.
*/
`timescale 1ns/10ps
module tb;
  import ascal_pkg::*;
  logic                i_mclk, i_nrst, i_raw_valid, i_raw_is_cal;
  logic [RES_BITS-1:0] i_raw_code, offset, ofs_m;
  logic                cs_n, sclk, sdo, sdo_oe, raw_ready, sample, iso, busy, done, pwr_frame, iso_d;
  logic [32:0]         bits;
  logic [40:0]         notes[$];
  logic [7:0]          conv_q[$], cal_q[$];
  logic [7:0]          codes[4] = '{LOWEST_CODE, MIDDLE_CODE, HIGHEST_CODE, 8'h03};
  wire                 sdo_line;
  int                  mismatches, checked, i;
  integer              seed;
  assign sdo_line = sdo_oe ? sdo : 1'bz;
  ascal_top i_ascal_top (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_sclk(sclk), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .i_raw_valid(i_raw_valid), .i_raw_code(i_raw_code), .i_raw_is_cal(i_raw_is_cal),
    .o_raw_ready(raw_ready), .o_sample(sample), .o_inputs_isolated(iso), .o_cal_busy(busy), .o_offset(offset));
  ascal_host i_ascal_host (.i_mclk(i_mclk), .i_sdo_line(sdo_line), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_done(done), .o_bits(bits));
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  function automatic logic [7:0] rnd8();
    logic [31:0] r;
    r = $random(seed);
    return r[7:0];
  endfunction
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic core_push(input logic [7:0] c, input logic cal);
    i_raw_valid <= 1'b1;
    i_raw_code <= c;
    i_raw_is_cal <= cal;
    do @(posedge i_mclk); while (raw_ready !== 1'b1);
    i_raw_valid <= 1'b0;
  endtask
  // Analog core stand-in: a conversion word on each sample outside the power-up frame, a measurement when inputs are isolated
  always @(posedge i_mclk) iso_d <= iso;
  initial forever begin
    @(posedge i_mclk);
    if (sample === 1'b1 && !pwr_frame && conv_q.size() > 0) core_push(conv_q.pop_front(), 1'b0);
    else if (iso === 1'b1 && iso_d === 1'b0 && cal_q.size() > 0) core_push(cal_q.pop_front(), 1'b1);
  end
  task automatic run_frame(input int n, input logic pwr, input logic [7:0] raw, input logic [7:0] meas);
    logic [32:0] exp;
    logic [7:0]  res;
    int          j;
    exp = 33'h0;
    res = (raw > ofs_m) ? raw - ofs_m : 8'h00;
    if (!pwr) for (j = 0; j < 8; j++) exp[2 + j] = res[7 - j];
    if ((pwr && n >= 16) || (!pwr && n >= 32)) ofs_m = meas;
    pwr_frame = pwr;
    if (!pwr) conv_q.push_back(raw);
    if (pwr || n >= 17) cal_q.push_back(meas);
    notes.push_back({exp, ofs_m});
    i_ascal_host.frame(n);
  endtask
  task automatic reset_dut();
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    ofs_m = OFFSET_RESET;
    repeat (4) @(posedge i_mclk);
  endtask
  // Result monitor: the oldest note must match each finished frame and the store after it
  always @(posedge i_mclk) begin
    if (done === 1'b1) begin
      checked++;
      if (notes.size() == 0) begin
        mismatches++;
        $display("MISMATCH at %0t: got %h expected %h", $time, {bits, offset}, 41'h0);
      end else if ({bits, offset} !== notes[0]) begin
        mismatches++;
        $display("MISMATCH at %0t: got %h expected %h", $time, {bits, offset}, notes[0]);
      end
      if (notes.size() > 0) void'(notes.pop_front());
    end
  end
  initial begin
    i_nrst = 1'b0;
    i_raw_valid = 1'b0;
    i_raw_code = 8'h00;
    i_raw_is_cal = 1'b0;
    seed = 32'h58f161c2;
    pwr_frame = 1'b0;
    mismatches = 0;
    checked = 0;
    reset_dut();
    run_frame(15, 1'b1, 8'h00, 8'h21);
    run_frame(16, 1'b0, rnd8(), 8'h00);
    // Fill the buffer with no frame open until it refuses; the reset below empties it
    i_raw_valid <= 1'b1;
    i = 0;
    repeat (20) begin
      i_raw_code <= rnd8();
      @(posedge i_mclk);
      if (raw_ready === 1'b1) i++;
    end
    i_raw_valid <= 1'b0;
    checked++;
    if (i != FIFO_DEPTH) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, i, FIFO_DEPTH);
    end
    reset_dut();
    run_frame(16, 1'b1, 8'h00, 8'h05);
    for (i = 0; i < 4; i++) run_frame(16, 1'b0, codes[i], 8'h00);
    repeat (4) run_frame(16, 1'b0, rnd8(), 8'h00);
    run_frame(31, 1'b0, 8'h40, 8'h09);
    run_frame(32, 1'b0, 8'h40, 8'h09);
    run_frame(16, 1'b0, 8'h80, 8'h00);
    repeat (4) @(posedge i_mclk);
    test_done();
  end
  initial begin
    #2000000;
    mismatches++;
    test_done();
  end
endmodule // tb
